// File: inc/smt_pkg.sv
package smt_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam int          NUM_CH      = 7;
  localparam int          CH1_IDX     = 1;
  localparam logic [6:0]  SLAVE_ADDR  = 7'h1A;
  localparam logic [7:0]  OFF_LOCAL   = 8'h07;
  localparam logic [7:0]  OFF_REMOTE1 = 8'h01;
  localparam logic [7:0]  OFF_REMOTE2 = 8'h02;
  localparam logic [7:0]  OFF_REMOTE3 = 8'h03;
  localparam logic [7:0]  OFF_REMOTE4 = 8'h04;
  localparam logic [7:0]  OFF_REMOTE5 = 8'h05;
  localparam logic [7:0]  OFF_REMOTE6 = 8'h06;
  localparam logic [7:0]  OFF_EXT1    = 8'h09;
  localparam logic [7:0]  OFF_CFG     = 8'h41;
  localparam int          CFG_TO_DIS  = 5;
  localparam logic [7:0]  CMD_POR     = 8'h00;
  localparam logic [7:0]  CFG_POR     = 8'h00;
  localparam logic [7:0]  TEMP_POR    = 8'h00;
  localparam logic [7:0]  TEMP_MAX    = 8'h7F;
  localparam logic [7:0]  TEMP_MIN    = 8'h00;
  localparam logic [7:0]  DIODE_OPEN  = 8'hFF;
  localparam logic [7:0]  DIODE_SHORT = 8'hEE;

  // Channel index 0 is the local sensor, 1..6 the remote diodes
  localparam logic [NUM_CH-1:0][7:0] TEMP_OFF = {
    OFF_REMOTE6, OFF_REMOTE5, OFF_REMOTE4, OFF_REMOTE3,
    OFF_REMOTE2, OFF_REMOTE1, OFF_LOCAL};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 40_000_000;
  localparam int TIMEOUT_MS = 37;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int CNT_W      = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_CMD, ST_CACK,
    ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_WAIT
  } smt_st_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } smt_pins_t;

  // Raw conversion result, signed, in steps of 0.125 degree
  typedef struct packed {
    logic signed [11:0] raw;
    logic               open;
    logic               short;
  } smt_conv_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [2:0] frac;
  } smt_fmt_t;

  typedef struct packed {
    smt_st_t                  st;
    logic                     scl_p;
    logic                     sda_p;
    logic [7:0]               sh;
    logic [7:0]               tx;
    logic [2:0]               bits;
    logic                     done;
    logic                     rw;
    logic                     more;
    logic                     oe_n;
    logic [7:0]               ptr;
    logic [7:0]               cfg;
    logic [NUM_CH-1:0][7:0]   hi;
    logic [2:0]               ext;
    logic                     hold;
    logic [CNT_W-1:0]         hold_cnt;
    logic [CNT_W-1:0]         to_cnt;
  } smt_state_t;

  localparam smt_state_t STATE_POR = '{
    st: ST_IDLE, scl_p: 1'b1, sda_p: 1'b1, sh: 8'h00, tx: 8'h00,
    bits: 3'h0, done: 1'b0, rw: 1'b0, more: 1'b0, oe_n: 1'b1,
    ptr: CMD_POR, cfg: CFG_POR, hi: {NUM_CH{TEMP_POR}}, ext: 3'h0,
    hold: 1'b0, hold_cnt: '0, to_cnt: '0};

endpackage

// File: hdl/smt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module smt_sync (
  input  wire logic              clk_i,  // System clock
  input  wire logic              rst_i,  // Synchronous reset
  input  wire smt_pkg::smt_pins_t pins_i, // Raw bus pins
  output var  smt_pkg::smt_pins_t pins_o // Synchronised pins
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser; idle bus level is high
  // ----------------------------------------------------------------
  smt_pkg::smt_pins_t [1:0] q_reg;
  smt_pkg::smt_pins_t [1:0] q_next;

  always_comb begin
    q_next = {q_reg[0], pins_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_reg <= {2{2'b11}};
    end else begin
      q_reg <= q_next;
    end
  end

  assign pins_o = q_reg[1];

endmodule
`default_nettype wire

// File: hdl/smt_temp_fmt.sv
`timescale 1ns/1ps
`default_nettype none
module smt_temp_fmt #(
  parameter bit FULL_RES = 1'b0
) (
  input  wire smt_pkg::smt_conv_t conv_i, // Raw conversion result
  output smt_pkg::smt_fmt_t       fmt_o   // Register image
);

  logic signed [8:0] whole;

  always_comb begin
    whole = conv_i.raw[11:3];
    fmt_o = '{hi: smt_pkg::TEMP_MIN, frac: 3'h0};
    if (conv_i.open) begin
      fmt_o.hi = smt_pkg::DIODE_OPEN;
    end else if (conv_i.short) begin
      fmt_o.hi = smt_pkg::DIODE_SHORT;
    end else if (whole < 0) begin
      fmt_o.hi = smt_pkg::TEMP_MIN;
    end else if (whole > 9'sd127) begin
      fmt_o.hi = smt_pkg::TEMP_MAX;
    end else begin
      fmt_o.hi = whole[7:0];
      // three fraction bits on channel 1
      if (FULL_RES) begin
        fmt_o.frac = conv_i.raw[2:0];
      end
    end
  end

endmodule
`default_nettype wire

// File: hdl/smt_smbus_top.sv
// Behaviour
// - Results and control appear as 8-bit registers.
// - Only one slave address is answered; all registers behind it.
// - Write byte, read byte, send byte and receive byte only.
// - Receive byte returns the register the stored pointer selects.
// - Channel 1 has 11 bits, LSB of 0.125 degree.
// - Other channels are 8 bits, one degree per count.
// - High byte in main register, three fraction bits in extended.
// - Reading extended register freezes channel 1 until high byte read.
// - Freeze released after one bus timeout, about 37 ms.
// - High byte unsigned, clamped to 0..127.
// - Open diode reads FF, shorted diode reads EE.
`timescale 1ns/1ps
`default_nettype none
module smt_smbus_top #(
  parameter int TIMEOUT_CYC = smt_pkg::TIMEOUT_CYC
) (
  input  wire logic                        clk_i,        // 40 MHz clock
  input  wire logic                        rst_i,        // Sync reset
  input  wire logic                        scl_i,        // Bus clock pin
  input  wire logic                        sda_i,        // Bus data pin in
  output logic                             sda_o,        // Bus data out
  output logic                             sda_oe_n_o,   // Low: drive pin
  input  wire logic [smt_pkg::NUM_CH-1:0]  conv_valid_i, // Result strobe
  input  wire smt_pkg::smt_conv_t [smt_pkg::NUM_CH-1:0] conv_i // Results
);

  // ----------------------------------------------------------------
  // Pin synchronisers and result formatting
  // ----------------------------------------------------------------
  smt_pkg::smt_pins_t                 pin;
  smt_pkg::smt_fmt_t [smt_pkg::NUM_CH-1:0] fmt;
  smt_pkg::smt_state_t                q_reg;
  smt_pkg::smt_state_t                q_next;
  localparam logic [smt_pkg::CNT_W-1:0] CNT_LAST =
    smt_pkg::CNT_W'(TIMEOUT_CYC - 1);

  smt_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pins_i ({scl_i, sda_i}),
    .pins_o (pin)
  );

  for (genvar c = 0; c < smt_pkg::NUM_CH; c++) begin : g_fmt
    smt_temp_fmt #(
      .FULL_RES (c == smt_pkg::CH1_IDX)
    ) u_fmt (
      .conv_i (conv_i[c]),
      .fmt_o  (fmt[c])
    );
  end

  // ----------------------------------------------------------------
  // Bus events and read data
  // ----------------------------------------------------------------
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       load;
  logic [7:0] rd_byte;

  always_comb begin
    rise  = !q_reg.scl_p && pin.scl;
    fall  = q_reg.scl_p && !pin.scl;
    start = q_reg.scl_p && pin.scl && q_reg.sda_p && !pin.sda;
    stop  = q_reg.scl_p && pin.scl && !q_reg.sda_p && pin.sda;
    load  = fall && ((q_reg.st == smt_pkg::ST_AACK && q_reg.rw) ||
                     (q_reg.st == smt_pkg::ST_RACK && q_reg.more));
    rd_byte = 8'h00;
    for (int c = 0; c < smt_pkg::NUM_CH; c++) begin
      if (q_reg.ptr == smt_pkg::TEMP_OFF[c]) begin
        rd_byte = q_reg.hi[c];
      end
    end
    // fraction sits in the top bits
    if (q_reg.ptr == smt_pkg::OFF_EXT1) begin
      rd_byte = {q_reg.ext, 5'h00};
    end
    if (q_reg.ptr == smt_pkg::OFF_CFG) begin
      rd_byte = q_reg.cfg;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    q_next       = q_reg;
    q_next.scl_p = pin.scl;
    q_next.sda_p = pin.sda;

    for (int c = 0; c < smt_pkg::NUM_CH; c++) begin
      if (conv_valid_i[c] && !(c == smt_pkg::CH1_IDX && q_reg.hold)) begin
        q_next.hi[c] = fmt[c].hi;
        if (c == smt_pkg::CH1_IDX) begin
          q_next.ext = fmt[c].frac;
        end
      end
    end

    if (q_reg.hold) begin
      if (q_reg.hold_cnt == CNT_LAST) begin
        q_next.hold = 1'b0;
      end else begin
        q_next.hold_cnt = q_reg.hold_cnt + 1'b1;
      end
    end

    unique case (q_reg.st)
      smt_pkg::ST_IDLE, smt_pkg::ST_WAIT: begin
      end
      smt_pkg::ST_ADDR, smt_pkg::ST_CMD, smt_pkg::ST_WDATA: begin
        if (rise) begin
          q_next.sh   = {q_reg.sh[6:0], pin.sda};
          q_next.bits = q_reg.bits + 3'h1;
          q_next.done = (q_reg.bits == 3'h7);
        end else if (fall && q_reg.done) begin
          q_next.done = 1'b0;
          q_next.oe_n = 1'b0;
          if (q_reg.st == smt_pkg::ST_ADDR) begin
            if (q_reg.sh[7:1] == smt_pkg::SLAVE_ADDR) begin
              q_next.rw = q_reg.sh[0];
              q_next.st = smt_pkg::ST_AACK;
            end else begin
              q_next.oe_n = 1'b1;
              q_next.st   = smt_pkg::ST_WAIT;
            end
          end else if (q_reg.st == smt_pkg::ST_CMD) begin
            q_next.ptr = q_reg.sh;
            q_next.st  = smt_pkg::ST_CACK;
          end else begin
            if (q_reg.ptr == smt_pkg::OFF_CFG) begin
              q_next.cfg = q_reg.sh;
            end
            q_next.st = smt_pkg::ST_WACK;
          end
        end
      end
      smt_pkg::ST_AACK: begin
        if (fall && !q_reg.rw) begin
          q_next.oe_n = 1'b1;
          q_next.bits = 3'h0;
          q_next.st   = smt_pkg::ST_CMD;
        end
      end
      smt_pkg::ST_CACK: begin
        if (fall) begin
          q_next.oe_n = 1'b1;
          q_next.bits = 3'h0;
          q_next.st   = smt_pkg::ST_WDATA;
        end
      end
      smt_pkg::ST_WACK: begin
        // one data byte only; more is not acked
        if (fall) begin
          q_next.oe_n = 1'b1;
          q_next.st   = smt_pkg::ST_WAIT;
        end
      end
      smt_pkg::ST_RDATA: begin
        if (rise) begin
          q_next.bits = q_reg.bits + 3'h1;
          q_next.done = (q_reg.bits == 3'h7);
        end else if (fall) begin
          if (q_reg.done) begin
            q_next.done = 1'b0;
            q_next.oe_n = 1'b1;
            q_next.st   = smt_pkg::ST_RACK;
          end else begin
            q_next.tx   = {q_reg.tx[6:0], 1'b0};
            q_next.oe_n = q_reg.tx[6];
          end
        end
      end
      smt_pkg::ST_RACK: begin
        if (rise) begin
          q_next.more = !pin.sda;
        end else if (fall && !q_reg.more) begin
          q_next.st = smt_pkg::ST_WAIT;
        end
      end
    endcase

    if (load) begin
      q_next.tx   = rd_byte;
      q_next.oe_n = rd_byte[7];
      q_next.bits = 3'h0;
      q_next.done = 1'b0;
      q_next.more = 1'b0;
      q_next.st   = smt_pkg::ST_RDATA;
      if (q_reg.ptr == smt_pkg::OFF_EXT1) begin
        q_next.hold     = 1'b1;
        q_next.hold_cnt = '0;
      end else if (q_reg.ptr == smt_pkg::OFF_REMOTE1) begin
        q_next.hold = 1'b0;
      end
    end

    // Bus stuck low too long frees the data line for the host
    if (q_reg.st != smt_pkg::ST_IDLE && !pin.scl) begin
      q_next.to_cnt = q_reg.to_cnt + 1'b1;
    end else begin
      q_next.to_cnt = '0;
    end
    if (q_reg.to_cnt == CNT_LAST && !q_reg.cfg[smt_pkg::CFG_TO_DIS]) begin
      q_next.st     = smt_pkg::ST_IDLE;
      q_next.oe_n   = 1'b1;
      q_next.to_cnt = '0;
    end

    // Start and stop win over any byte in progress
    if (start) begin
      q_next.st   = smt_pkg::ST_ADDR;
      q_next.bits = 3'h0;
      q_next.done = 1'b0;
      q_next.oe_n = 1'b1;
    end else if (stop) begin
      q_next.st   = smt_pkg::ST_IDLE;
      q_next.oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_reg <= smt_pkg::STATE_POR;
    end else begin
      q_reg <= q_next;
    end
  end

  // Open drain: only ever pull low
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = q_reg.oe_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_rd_entry;
    q_reg.st == smt_pkg::ST_RDATA && $past(q_reg.st) != smt_pkg::ST_RDATA;
  endsequence

  sequence s_cmd_done;
    q_reg.st == smt_pkg::ST_CACK && $past(q_reg.st) == smt_pkg::ST_CMD;
  endsequence

  property p_addr_ack;
    @(posedge clk_i) disable iff (rst_i)
    q_reg.st == smt_pkg::ST_AACK |-> q_reg.sh[7:1] == smt_pkg::SLAVE_ADDR;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("ack given to foreign address");

  property p_rd_data;
    @(posedge clk_i) disable iff (rst_i)
    s_rd_entry |-> q_reg.tx == $past(rd_byte) && q_reg.oe_n == q_reg.tx[7];
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("read byte not taken from pointed register");

  property p_ptr_load;
    @(posedge clk_i) disable iff (rst_i)
    s_cmd_done |-> q_reg.ptr == q_reg.sh && !q_reg.oe_n;
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("command byte not loaded into pointer");

  property p_cfg_write;
    @(posedge clk_i) disable iff (rst_i)
    $changed(q_reg.cfg) |-> $past(q_reg.st) == smt_pkg::ST_WDATA &&
      q_reg.st == smt_pkg::ST_WACK;
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("register changed outside a write byte");

  property p_hold_freeze;
    @(posedge clk_i) disable iff (rst_i)
    q_reg.hold ##1 q_reg.hold |-> $stable(q_reg.hi[smt_pkg::CH1_IDX]);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("channel 1 high byte changed while held");

  property p_hold_limit;
    @(posedge clk_i) disable iff (rst_i)
    q_reg.hold && q_reg.hold_cnt == CNT_LAST && !load |=> !q_reg.hold;
  endproperty
  a_hold_limit: assert property (p_hold_limit)
    else $error("hold outlived the timeout");

  property p_clamp;
    @(posedge clk_i) disable iff (rst_i)
    conv_valid_i[0] && !conv_i[0].open && !conv_i[0].short |=>
      q_reg.hi[0] <= smt_pkg::TEMP_MAX;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("local reading outside 0..127");

  property p_open_code;
    @(posedge clk_i) disable iff (rst_i)
    conv_valid_i[2] && conv_i[2].open |=>
      q_reg.hi[2] == smt_pkg::DIODE_OPEN;
  endproperty
  a_open_code: assert property (p_open_code)
    else $error("open diode not reported as FF");

  property p_ext_frac;
    @(posedge clk_i) disable iff (rst_i)
    conv_valid_i[smt_pkg::CH1_IDX] && !q_reg.hold |=>
      q_reg.ext == $past(fmt[smt_pkg::CH1_IDX].frac);
  endproperty
  a_ext_frac: assert property (p_ext_frac)
    else $error("extended byte not updated with fraction");

  property p_nack_release;
    @(posedge clk_i) disable iff (rst_i)
    q_reg.st == smt_pkg::ST_RACK ##1 q_reg.st == smt_pkg::ST_WAIT |->
      q_reg.oe_n [*2];
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("data line held after host NACK");

endmodule
`default_nettype wire

// File: testbench/smt_host.sv
`timescale 1ns/1ps
`default_nettype none
module smt_host #(
  parameter int HALF = 10
) (
  input  wire logic clk_i, // System clock
  input  wire logic sda_i, // Wire level of data line
  output logic      scl_o, // Bus clock, high when idle
  output logic      sda_o  // Low pulls data line, high releases it
);
  // ------
  // Bus primitives
  // ------
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // single master, so short forms are safe on this bus
  // start, also used as repeated start
  task automatic start();
    sda_o = 1'b1;
    wt(HALF);
    scl_o = 1'b1;
    wt(HALF);
    sda_o = 1'b0;
    wt(HALF);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    sda_o = 1'b0;
    wt(HALF);
    scl_o = 1'b1;
    wt(HALF);
    sda_o = 1'b1;
    wt(HALF);
  endtask

  // eight bits MSB first, ninth is the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic a,
                         output logic [7:0] q, output logic ar);
    logic [8:0] s;
    s = {d, a};
    for (int i = 8; i >= 0; i--) begin
      sda_o = s[i];
      wt(HALF);
      scl_o = 1'b1;
      // Sample late in the high phase, after the sync delay
      wt(HALF);
      s[i] = sda_i;
      scl_o = 1'b0;
    end
    q = s[8:1];
    ar = s[0];
  endtask
endmodule
`default_nettype wire

// File: testbench/test_smt_smbus_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_smt_smbus_top;
  // Short hold timeout keeps the run brief
  localparam int         TO_CYC = 2000;
  localparam int         LIMIT  = 80000;
  localparam logic [7:0] AW     = {smt_pkg::SLAVE_ADDR, 1'b0};
  localparam logic [7:0] AR     = {smt_pkg::SLAVE_ADDR, 1'b1};

  logic                                     clk_i;
  logic                                     rst_i;
  logic                                     scl;
  logic                                     host_sda;
  logic                                     dev_sda;
  logic                                     dev_oe_n;
  logic                                     sda_w;
  logic [smt_pkg::NUM_CH-1:0]               conv_vld;
  smt_pkg::smt_conv_t [smt_pkg::NUM_CH-1:0] conv;
  smt_pkg::smt_conv_t                       tc [7];
  int                                       num_errors;
  int                                       checked;
  int                                       cyc;

  // Open drain wire with pull-up
  assign sda_w = host_sda & (dev_oe_n | dev_sda);

  smt_smbus_top #(.TIMEOUT_CYC(TO_CYC)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(dev_sda), .sda_oe_n_o(dev_oe_n),
    .conv_valid_i(conv_vld), .conv_i(conv));
  smt_host host_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
                   .sda_o(host_sda));

  // ------
  // Checking and bus tasks
  // ------
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp1(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic put(input logic [7:0] d, input logic ae);
    logic [7:0] q;
    logic       a;
    host_u.byte_io(d, 1'b1, q, a);
    cmp1("ack", ae, a);
  endtask

  task automatic get(input logic [7:0] e, input string n);
    logic [7:0] q;
    logic       a;
    host_u.byte_io(8'hFF, 1'b1, q, a);
    cmp8(n, e, q);
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host_u.start();
    put(AW, 1'b0);
    put(c, 1'b0);
    put(d, 1'b0);
    host_u.stop();
  endtask

  task automatic snd(input logic [7:0] c);
    host_u.start();
    put(AW, 1'b0);
    put(c, 1'b0);
    host_u.stop();
  endtask

  task automatic rd(input logic [7:0] c, input logic [7:0] e,
                    input string n);
    host_u.start();
    put(AW, 1'b0);
    put(c, 1'b0);
    host_u.start();
    put(AR, 1'b0);
    get(e, n);
    host_u.stop();
  endtask

  task automatic rcv(input logic [7:0] e, input string n);
    host_u.start();
    put(AR, 1'b0);
    get(e, n);
    host_u.stop();
  endtask

  task automatic pulse(input logic [smt_pkg::NUM_CH-1:0] m);
    conv_vld = m;
    host_u.wt(1);
    conv_vld = '0;
    host_u.wt(2);
  endtask

  function automatic logic [7:0] exp_hi(input smt_pkg::smt_conv_t v);
    if (v.open) return smt_pkg::DIODE_OPEN;
    if (v.short) return smt_pkg::DIODE_SHORT;
    if (v.raw[11]) return smt_pkg::TEMP_MIN;
    if (v.raw[10]) return smt_pkg::TEMP_MAX;
    return v.raw[10:3];
  endfunction

  function automatic logic [7:0] exp_ext(input smt_pkg::smt_conv_t v);
    if (v.open || v.short || v.raw[11] || v.raw[10]) return 8'h00;
    return {v.raw[2:0], 5'h00};
  endfunction

  // ------
  // Clock, watchdog and tests
  // ------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    rst_i = 1'b1;
    conv_vld = '0;
    conv = '0;
    num_errors = 0;
    checked = 0;
    tc = '{'{12'h0C8, 1'b0, 1'b0}, '{12'h0CD, 1'b0, 1'b0},
           '{12'h3FF, 1'b0, 1'b0}, '{12'h400, 1'b0, 1'b0},
           '{12'hFFF, 1'b0, 1'b0}, '{12'h000, 1'b1, 1'b0},
           '{12'h000, 1'b0, 1'b1}};
    host_u.wt(5);
    rst_i = 1'b0;
    host_u.wt(5);
    rd(smt_pkg::OFF_REMOTE1, smt_pkg::TEMP_POR, "ch1 reset");
    rd(smt_pkg::OFF_CFG, smt_pkg::CFG_POR, "cfg reset");
    host_u.start();
    put(AW ^ 8'h02, 1'b1);
    host_u.stop();
    // Every format case on every channel, extended byte first
    for (int k = 0; k < 7; k++) begin
      conv = {smt_pkg::NUM_CH{tc[k]}};
      pulse('1);
      rd(smt_pkg::OFF_EXT1, exp_ext(tc[k]), "ext");
      for (int c = 0; c < smt_pkg::NUM_CH; c++) begin
        rd(smt_pkg::TEMP_OFF[c], exp_hi(tc[k]), "high");
      end
    end
    // Distinct channel values show which register the pointer selects
    for (int c = 0; c < smt_pkg::NUM_CH; c++) begin
      conv[c] = '{12'(8 * (c + 10)), 1'b0, 1'b0};
    end
    pulse('1);
    snd(smt_pkg::OFF_LOCAL);
    rcv(8'h0A, "rcv local");
    rd(smt_pkg::OFF_REMOTE2, 8'h0C, "ch2");
    rcv(8'h0C, "rcv ch2");
    wr(smt_pkg::OFF_CFG, 8'h18);
    rd(smt_pkg::OFF_CFG, 8'h18, "cfg");
    wr(smt_pkg::OFF_REMOTE1, 8'h55);
    rcv(8'h0B, "ch1 read only");
    // Extended read holds channel 1 until its high byte is read
    conv[1] = tc[0];
    pulse(7'h02);
    rd(smt_pkg::OFF_EXT1, 8'h00, "ext lock");
    conv[1] = tc[2];
    pulse(7'h02);
    rd(smt_pkg::OFF_REMOTE1, 8'h19, "held");
    pulse(7'h02);
    rd(smt_pkg::OFF_REMOTE1, 8'h7F, "released");
    rd(smt_pkg::OFF_EXT1, 8'hE0, "ext relock");
    host_u.wt(TO_CYC + 100);
    conv[1] = tc[0];
    pulse(7'h02);
    rd(smt_pkg::OFF_REMOTE1, 8'h19, "after timeout");
    // Bus stall: released after the timeout, held when it is disabled
    host_u.start();
    put(AR, 1'b0);
    host_u.wt(TO_CYC + 20);
    cmp1("stall release", 1'b1, sda_w);
    host_u.stop();
    wr(smt_pkg::OFF_CFG, 8'h38);
    host_u.start();
    put(AR, 1'b0);
    host_u.wt(TO_CYC + 20);
    cmp1("stall held", 1'b0, sda_w);
    get(8'h38, "cfg after stall");
    host_u.stop();
    end_of_test();
  end
endmodule
`default_nettype wire
